// >>> rtl/rpc_manager_end.sv
/*
  Manager end: sends response, reject and removal packets downlink,
  classifies request, ack and leave packets arriving uplink.
  Assumes the user holds tx inputs stable while txBusy is high.
*/
module rpc_manager_end (
  input  wire logic               clk,
  input  wire logic               rst_n,
  rpc_link_if.mgr                 link,
  input  wire logic               txStart,
  input  rpc_pkg::rpc_kind_e      txKind,
  input  wire logic [13:0]        txIdent,
  input  wire logic               txRetain,
  input  wire logic [2:0]         txSegLimit,
  input  wire logic [1:0]         txProfile,
  input  wire logic [31:0]        txNonce,
  input  wire logic [191:0]       txSubnetKeyWrapped,
  input  wire logic [191:0]       txAuthKeyWrapped,
  output logic                    txBusy,
  output logic                    txRefused,
  output logic                    rxDone,
  output logic                    rxInvalid,
  output rpc_pkg::rpc_kind_e      rxKind,
  output logic [13:0]             rxIdent,
  output logic                    rxRetain,
  output logic [1:0]              rxProfile,
  output logic [31:0]             rxNonce,
  output logic                    dropConns,
  output logic                    keepConns,
  output logic                    leaveAck,
  output logic                    leaveReq
);
  rpc_pkg::rpc_tx_e   txState_ff;
  logic [3:0]         txLeft_ff;
  logic [3:0]         txIdx_ff;
  logic [31:0]        txHead;
  logic [3:0]         txWords;
  logic               txLegal;
  rpc_pkg::rpc_rx_e   rxState_ff;
  logic [3:0]         rxLeft_ff;
  rpc_pkg::rpc_kind_e hdrKind;
  logic [3:0]         hdrWords;
  logic               hdrOk;
  logic               rxFinish;
  logic               rxFail;
  rpc_pkg::rpc_kind_e finKind;
  logic               finRetain;
  logic               pendLeave_ff;

  // Only well-formed downlink kinds may leave this end
  always_comb
  begin
    txHead = rpc_pkg::buildHeader(txKind, txIdent, txRetain, txSegLimit,
                                  txProfile);
    txWords = rpc_pkg::payloadWords(txKind, txProfile);
    txLegal = (rpc_pkg::classify(txHead) == txKind) &&
              (txKind inside {rpc_pkg::K_GRANT, rpc_pkg::K_DENY,
                              rpc_pkg::K_LVM});
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      txState_ff   <= rpc_pkg::TX_IDLE;
      txLeft_ff    <= 4'h0;
      txIdx_ff     <= 4'h0;
      txBusy       <= 1'b0;
      txRefused    <= 1'b0;
      link.dnValid <= 1'b0;
      link.dnData  <= 32'h0000_0000;
      link.dnLast  <= 1'b0;
    end
    else
    begin
      txRefused <= 1'b0;
      unique case (txState_ff)
        rpc_pkg::TX_IDLE:
        begin
          if (txStart && txLegal)
          begin
            txState_ff   <= rpc_pkg::TX_SEND;
            txBusy       <= 1'b1;
            link.dnValid <= 1'b1;
            link.dnData  <= txHead;
            link.dnLast  <= (txWords == rpc_pkg::WORDS_NONE);
            txLeft_ff    <= txWords;
            txIdx_ff     <= 4'h0;
          end
          else if (txStart)
            txRefused <= 1'b1;
        end
        rpc_pkg::TX_SEND:
        begin
          if (txLeft_ff != 4'h0)
          begin
            // Keys are taken only from the wrapped inputs
            link.dnData <= rpc_pkg::pickWord(txIdx_ff, txNonce,
                               txSubnetKeyWrapped,
                               txAuthKeyWrapped);
            link.dnLast <= (txLeft_ff == 4'h1);
            txLeft_ff   <= txLeft_ff - 4'h1;
            txIdx_ff    <= txIdx_ff + 4'h1;
          end
          else
          begin
            txState_ff   <= rpc_pkg::TX_IDLE;
            txBusy       <= 1'b0;
            link.dnValid <= 1'b0;
            link.dnLast  <= 1'b0;
          end
        end
      endcase
    end
  end

  // Header check and end-of-packet decision for the uplink stream
  always_comb
  begin
    hdrKind = rpc_pkg::classify(link.upData);
    hdrWords = rpc_pkg::payloadWords(hdrKind,
                 link.upData[rpc_pkg::HDR_PROF +: rpc_pkg::PROF_W]);
    hdrOk = (hdrKind inside {rpc_pkg::K_ASK, rpc_pkg::K_ACK,
                             rpc_pkg::K_LVN}) &&
            ((hdrWords == rpc_pkg::WORDS_NONE) == link.upLast);
    rxFinish = 1'b0;
    rxFail = 1'b0;
    finKind = rxKind;
    finRetain = rxRetain;
    if (link.upValid)
    begin
      unique case (rxState_ff)
        rpc_pkg::RX_IDLE:
        begin
          finKind = hdrKind;
          finRetain = link.upData[rpc_pkg::HDR_RET];
          rxFinish = hdrOk && link.upLast;
          rxFail = !hdrOk;
        end
        rpc_pkg::RX_PAY:
        begin
          rxFinish = link.upLast && (rxLeft_ff == 4'h1);
          rxFail = link.upLast != (rxLeft_ff == 4'h1);
        end
        rpc_pkg::RX_SKIP:
        begin
          rxFinish = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rxState_ff <= rpc_pkg::RX_IDLE;
      rxLeft_ff  <= 4'h0;
      rxKind     <= rpc_pkg::K_BAD;
      rxIdent    <= 14'h0000;
      rxRetain   <= 1'b0;
      rxProfile  <= 2'h0;
      rxNonce    <= 32'h0000_0000;
    end
    else if (link.upValid)
    begin
      unique case (rxState_ff)
        rpc_pkg::RX_IDLE:
        begin
          if (hdrOk)
          begin
            rxKind    <= hdrKind;
            rxIdent   <= link.upData[rpc_pkg::HDR_ID +: rpc_pkg::IDENT_W];
            rxRetain  <= link.upData[rpc_pkg::HDR_RET];
            rxProfile <= link.upData[rpc_pkg::HDR_PROF +: rpc_pkg::PROF_W];
            rxLeft_ff <= hdrWords;
            if (!link.upLast)
              rxState_ff <= rpc_pkg::RX_PAY;
          end
          else if (!link.upLast)
            rxState_ff <= rpc_pkg::RX_SKIP;
        end
        rpc_pkg::RX_PAY:
        begin
          rxNonce   <= link.upData;
          rxLeft_ff <= rxLeft_ff - 4'h1;
          if (link.upLast)
            rxState_ff <= rpc_pkg::RX_IDLE;
          else if (rxLeft_ff == 4'h1)
            rxState_ff <= rpc_pkg::RX_SKIP;
        end
        rpc_pkg::RX_SKIP:
        begin
          if (link.upLast)
            rxState_ff <= rpc_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // Own removal request outstanding; a send in the same cycle wins
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pendLeave_ff <= 1'b0;
    else if (txState_ff == rpc_pkg::TX_IDLE && txStart && txLegal &&
             txKind == rpc_pkg::K_LVM)
      pendLeave_ff <= 1'b1;
    else if (rxFinish && finKind == rpc_pkg::K_LVN)
      pendLeave_ff <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rxDone    <= 1'b0;
      rxInvalid <= 1'b0;
      dropConns <= 1'b0;
      keepConns <= 1'b0;
      leaveAck  <= 1'b0;
      leaveReq  <= 1'b0;
    end
    else
    begin
      rxDone    <= rxFinish;
      rxInvalid <= rxFail;
      dropConns <= rxFinish && finKind == rpc_pkg::K_ASK &&
                   !finRetain;
      keepConns <= rxFinish && finKind == rpc_pkg::K_ASK &&
                   finRetain;
      leaveAck  <= rxFinish && finKind == rpc_pkg::K_LVN &&
                   pendLeave_ff;
      leaveReq  <= rxFinish && finKind == rpc_pkg::K_LVN &&
                   !pendLeave_ff;
    end
  end
endmodule : rpc_manager_end

// >>> rtl/rpc_pkg.sv
/*
  Shared constants, kinds and helpers for the registration packet link.
  Assumes one MAC clock; both ends compile against this package.
*/
// Notes on behaviour
// - Request: uplink, ident 3FFF, retain 0 drops links
// - Request with retain 1 keeps earlier links
// - Response: downlink, assigned ident, retain echoed
// - Ack: uplink, assigned ident, negative 0
// - Reject: downlink, ident 3FFF, negative 1, retain 0
// - Uplink negative assigned-ident packet: node leaves
// - Downlink negative assigned-ident packet: manager removes node
// - Leave answering a leave acts as acknowledge
// - Wrapped keys only in secure response
// - Manager sends keys only in wrapped form
// - Nonce only in secure request, response, reject
// - Nonce counter is 32 bits
// - Wrapped subnet key is 192 bits
// - Wrapped auth key is 192 bits
// - Segment limit nonzero only in response
package rpc_pkg;
  localparam int WORD_W    = 32;
  localparam int NONCE_W   = 32;
  localparam int KEY_W     = 192;
  localparam int KEY_WORDS = 6;
  localparam int IDENT_W   = 14;
  localparam int SAR_W     = 3;
  localparam int PROF_W    = 2;
  localparam int HDR_DIR   = 31;
  localparam int HDR_NEG   = 30;
  localparam int HDR_RET   = 29;
  localparam int HDR_ID    = 15;
  localparam int HDR_SAR   = 12;
  localparam int HDR_PROF  = 10;
  localparam logic [13:0] IDENT_NONE  = 14'h3FFF;
  localparam logic [3:0]  WORDS_NONE  = 4'h0;
  localparam logic [3:0]  WORDS_NONCE = 4'h1;
  localparam logic [3:0]  WORDS_FULL  = 4'hD;
  localparam logic [1:0]  PROF_ONE    = 2'h1;
  localparam logic [1:0]  PROF_TWO    = 2'h2;
  localparam logic [2:0]  SAR_NONE    = 3'h0;

  typedef enum logic [2:0] {
    K_BAD, K_ASK, K_GRANT, K_ACK, K_DENY, K_LVN, K_LVM
  } rpc_kind_e;
  typedef enum logic {TX_IDLE, TX_SEND} rpc_tx_e;
  typedef enum logic [1:0] {RX_IDLE, RX_PAY, RX_SKIP} rpc_rx_e;

  function automatic rpc_kind_e classify(input logic [31:0] h);
    logic dn;
    logic ng;
    logic rt;
    logic un;
    dn = h[HDR_DIR];
    ng = h[HDR_NEG];
    rt = h[HDR_RET];
    un = (h[HDR_ID +: IDENT_W] == IDENT_NONE);
    classify = K_BAD;
    if (!dn && un && !ng)
      classify = K_ASK;
    else if (dn && !un && !ng)
      classify = K_GRANT;
    else if (!dn && !un && !ng)
      classify = K_ACK;
    else if (dn && un && ng && !rt)
      classify = K_DENY;
    else if (!dn && !un && ng && !rt)
      classify = K_LVN;
    else if (dn && !un && ng && !rt)
      classify = K_LVM;
    if (classify != K_GRANT && h[HDR_SAR +: SAR_W] != SAR_NONE)
      classify = K_BAD;
  endfunction : classify

  function automatic logic [3:0] payloadWords(input rpc_kind_e k,
                                              input logic [1:0] prof);
    logic sec;
    sec = (prof == PROF_ONE) || (prof == PROF_TWO);
    if (sec && k == K_GRANT)
      payloadWords = WORDS_FULL;
    else if (sec && (k == K_ASK || k == K_DENY))
      payloadWords = WORDS_NONCE;
    else
      payloadWords = WORDS_NONE;
  endfunction : payloadWords

  function automatic logic [31:0] buildHeader(input rpc_kind_e k,
      input logic [13:0] id, input logic rt, input logic [2:0] sar,
      input logic [1:0] prof);
    logic [31:0] h;
    h = '0;
    h[HDR_DIR] = (k == K_GRANT) || (k == K_DENY) || (k == K_LVM);
    h[HDR_NEG] = (k == K_DENY) || (k == K_LVN) || (k == K_LVM);
    h[HDR_RET] = rt && (k == K_ASK || k == K_GRANT || k == K_ACK);
    h[HDR_ID +: IDENT_W] = (k == K_ASK || k == K_DENY) ? IDENT_NONE : id;
    h[HDR_SAR +: SAR_W] = (k == K_GRANT) ? sar : SAR_NONE;
    h[HDR_PROF +: PROF_W] = prof;
    buildHeader = h;
  endfunction : buildHeader

  // Payload word order: nonce, subnet key high first, auth key high first
  function automatic logic [31:0] pickWord(input logic [3:0] idx,
      input logic [31:0] nonce, input logic [191:0] sk,
      input logic [191:0] ak);
    int pos;
    pos = 0;
    if (idx == WORDS_NONE)
      pickWord = nonce;
    else if (int'(idx) <= KEY_WORDS)
    begin
      pos = KEY_W - WORD_W * int'(idx);
      pickWord = sk[pos +: WORD_W];
    end
    else
    begin
      pos = KEY_W - WORD_W * (int'(idx) - KEY_WORDS);
      pickWord = ak[pos +: WORD_W];
    end
  endfunction : pickWord
endpackage : rpc_pkg

// >>> rtl/rpc_link_if.sv
/*
  Word stream between the manager end and the joining node end.
  Assumes both ends share one clock; the bench joins them.
*/
interface rpc_link_if;
  logic        dnValid;
  logic [31:0] dnData;
  logic        dnLast;
  logic        upValid;
  logic [31:0] upData;
  logic        upLast;
  modport mgr (output dnValid, dnData, dnLast,
               input upValid, upData, upLast);
  modport node (input dnValid, dnData, dnLast,
                output upValid, upData, upLast);
endinterface : rpc_link_if

// >>> rtl/rpc_node_end.sv
/*
  Joining node end: sends request, ack and leave packets uplink,
  classifies response, reject and removal packets arriving downlink.
  Assumes the user holds tx inputs stable while txBusy is high.
*/
module rpc_node_end (
  input  wire logic               clk,
  input  wire logic               rst_n,
  rpc_link_if.node                link,
  input  wire logic               txStart,
  input  rpc_pkg::rpc_kind_e      txKind,
  input  wire logic [13:0]        txIdent,
  input  wire logic               txRetain,
  input  wire logic [1:0]         txProfile,
  input  wire logic [31:0]        txNonce,
  output logic                    txBusy,
  output logic                    txRefused,
  output logic                    rxDone,
  output logic                    rxInvalid,
  output rpc_pkg::rpc_kind_e      rxKind,
  output logic [13:0]             assignedIdent,
  output logic                    rxRetain,
  output logic [2:0]              rxSegLimit,
  output logic [31:0]             rxNonce,
  output logic [383:0]            rxKeys,
  output logic                    leaveAck,
  output logic                    leaveReq
);
  rpc_pkg::rpc_tx_e   txState_ff;
  logic [3:0]         txLeft_ff;
  logic [31:0]        txHead;
  logic [3:0]         txWords;
  logic               txLegal;
  rpc_pkg::rpc_rx_e   rxState_ff;
  logic [3:0]         rxLeft_ff;
  logic [3:0]         rxIdx_ff;
  rpc_pkg::rpc_kind_e hdrKind;
  logic [3:0]         hdrWords;
  logic               hdrOk;
  logic               rxFinish;
  logic               rxFail;
  rpc_pkg::rpc_kind_e finKind;
  logic               pendLeave_ff;

  always_comb
  begin
    txHead = rpc_pkg::buildHeader(txKind, txIdent, txRetain,
                                  rpc_pkg::SAR_NONE, txProfile);
    txWords = rpc_pkg::payloadWords(txKind, txProfile);
    txLegal = (rpc_pkg::classify(txHead) == txKind) &&
              (txKind inside {rpc_pkg::K_ASK, rpc_pkg::K_ACK,
                              rpc_pkg::K_LVN});
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      txState_ff   <= rpc_pkg::TX_IDLE;
      txLeft_ff    <= 4'h0;
      txBusy       <= 1'b0;
      txRefused    <= 1'b0;
      link.upValid <= 1'b0;
      link.upData  <= 32'h0000_0000;
      link.upLast  <= 1'b0;
    end
    else
    begin
      txRefused <= 1'b0;
      unique case (txState_ff)
        rpc_pkg::TX_IDLE:
        begin
          if (txStart && txLegal)
          begin
            txState_ff   <= rpc_pkg::TX_SEND;
            txBusy       <= 1'b1;
            link.upValid <= 1'b1;
            link.upData  <= txHead;
            link.upLast  <= (txWords == rpc_pkg::WORDS_NONE);
            txLeft_ff    <= txWords;
          end
          else if (txStart)
            txRefused <= 1'b1;
        end
        rpc_pkg::TX_SEND:
        begin
          if (txLeft_ff != 4'h0)
          begin
            link.upData <= txNonce;
            link.upLast <= (txLeft_ff == 4'h1);
            txLeft_ff   <= txLeft_ff - 4'h1;
          end
          else
          begin
            txState_ff   <= rpc_pkg::TX_IDLE;
            txBusy       <= 1'b0;
            link.upValid <= 1'b0;
            link.upLast  <= 1'b0;
          end
        end
      endcase
    end
  end

  always_comb
  begin
    hdrKind = rpc_pkg::classify(link.dnData);
    hdrWords = rpc_pkg::payloadWords(hdrKind,
                 link.dnData[rpc_pkg::HDR_PROF +: rpc_pkg::PROF_W]);
    hdrOk = (hdrKind inside {rpc_pkg::K_GRANT, rpc_pkg::K_DENY,
                             rpc_pkg::K_LVM}) &&
            ((hdrWords == rpc_pkg::WORDS_NONE) == link.dnLast);
    rxFinish = 1'b0;
    rxFail = 1'b0;
    finKind = rxKind;
    if (link.dnValid)
    begin
      unique case (rxState_ff)
        rpc_pkg::RX_IDLE:
        begin
          finKind = hdrKind;
          rxFinish = hdrOk && link.dnLast;
          rxFail = !hdrOk;
        end
        rpc_pkg::RX_PAY:
        begin
          rxFinish = link.dnLast && (rxLeft_ff == 4'h1);
          rxFail = link.dnLast != (rxLeft_ff == 4'h1);
        end
        rpc_pkg::RX_SKIP:
        begin
          rxFinish = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rxState_ff <= rpc_pkg::RX_IDLE;
      rxLeft_ff  <= 4'h0;
      rxIdx_ff   <= 4'h0;
      rxKind     <= rpc_pkg::K_BAD;
      rxRetain   <= 1'b0;
      rxSegLimit <= 3'h0;
      rxNonce    <= 32'h0000_0000;
      rxKeys     <= '0;
    end
    else if (link.dnValid)
    begin
      unique case (rxState_ff)
        rpc_pkg::RX_IDLE:
        begin
          if (hdrOk)
          begin
            rxKind     <= hdrKind;
            rxRetain   <= link.dnData[rpc_pkg::HDR_RET];
            rxSegLimit <= link.dnData[rpc_pkg::HDR_SAR +: rpc_pkg::SAR_W];
            rxLeft_ff  <= hdrWords;
            rxIdx_ff   <= 4'h0;
            if (!link.dnLast)
              rxState_ff <= rpc_pkg::RX_PAY;
          end
          else if (!link.dnLast)
            rxState_ff <= rpc_pkg::RX_SKIP;
        end
        rpc_pkg::RX_PAY:
        begin
          // Subnet key lands in the upper half, auth key in the lower
          if (rxIdx_ff == 4'h0)
            rxNonce <= link.dnData;
          else
            rxKeys <= {rxKeys[351:0], link.dnData};
          rxIdx_ff  <= rxIdx_ff + 4'h1;
          rxLeft_ff <= rxLeft_ff - 4'h1;
          if (link.dnLast)
            rxState_ff <= rpc_pkg::RX_IDLE;
          else if (rxLeft_ff == 4'h1)
            rxState_ff <= rpc_pkg::RX_SKIP;
        end
        rpc_pkg::RX_SKIP:
        begin
          if (link.dnLast)
            rxState_ff <= rpc_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // Assigned ident taken from a response header
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      assignedIdent <= rpc_pkg::IDENT_NONE;
    else if (link.dnValid && rxState_ff == rpc_pkg::RX_IDLE && hdrOk &&
             hdrKind == rpc_pkg::K_GRANT)
      assignedIdent <= link.dnData[rpc_pkg::HDR_ID +: rpc_pkg::IDENT_W];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pendLeave_ff <= 1'b0;
    else if (txState_ff == rpc_pkg::TX_IDLE && txStart && txLegal &&
             txKind == rpc_pkg::K_LVN)
      pendLeave_ff <= 1'b1;
    else if (rxFinish && finKind == rpc_pkg::K_LVM)
      pendLeave_ff <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rxDone    <= 1'b0;
      rxInvalid <= 1'b0;
      leaveAck  <= 1'b0;
      leaveReq  <= 1'b0;
    end
    else
    begin
      rxDone    <= rxFinish;
      rxInvalid <= rxFail;
      leaveAck  <= rxFinish && finKind == rpc_pkg::K_LVM &&
                   pendLeave_ff;
      leaveReq  <= rxFinish && finKind == rpc_pkg::K_LVM &&
                   !pendLeave_ff;
    end
  end
endmodule : rpc_node_end

// >>> tb/rpc_link_assertions.sv
/*
  Wire checks on the registration packet link.
  Assumes the bench instantiates it beside the link interface.
*/
module rpc_link_assertions (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        dnValid,
  input wire logic [31:0] dnData,
  input wire logic        dnLast,
  input wire logic        upValid,
  input wire logic [31:0] upData,
  input wire logic        upLast
);
  logic dnMid_ff;
  logic upMid_ff;
  logic dnHdr;
  logic upHdr;

  // Set while inside a frame, so the next valid word is payload
  always_ff @(posedge clk)
    dnMid_ff <= rst_n && dnValid && !dnLast;
  always_ff @(posedge clk)
    upMid_ff <= rst_n && upValid && !upLast;

  assign dnHdr = dnValid && !dnMid_ff;
  assign upHdr = upValid && !upMid_ff;

  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence sKeys;
    (dnValid && !dnLast) [*8] ##1 (dnValid && !dnLast) [*4]
      ##1 (dnValid && dnLast);
  endsequence
  sequence sNonceUp;
    !upLast ##1 (upValid && upLast);
  endsequence

  chk_dn_dir_bit:
  assert property (dnHdr |-> dnData[31]) else $error("dn dir");
  chk_up_dir_bit:
  assert property (upHdr |-> !upData[31]) else $error("up dir");
  chk_up_seg_zero:
  assert property (upHdr |-> upData[14:12] == 3'h0) else $error("up seg");
  chk_dn_neg_fields:
  assert property (dnHdr && dnData[30] |-> !dnData[29]
    && dnData[14:12] == 3'h0) else $error("dn neg fields");
  chk_up_leave_fields:
  assert property (upHdr && upData[30] |-> !upData[29]
    && !(&upData[28:15])) else $error("up leave fields");
  chk_up_ask_pos:
  assert property (upHdr && &upData[28:15] |-> !upData[30])
    else $error("up ask neg");
  chk_up_ask_nonce:
  assert property (upHdr && &upData[28:15] && ^upData[11:10]
    |-> sNonceUp) else $error("up nonce len");
  chk_up_no_pay:
  assert property (upHdr && !(&upData[28:15] && ^upData[11:10])
    |-> upLast) else $error("up pay len");
  chk_dn_key_run:
  assert property (dnHdr && ^dnData[11:10] && !dnData[30]
    |-> !dnLast ##1 sKeys) else $error("dn key len");
  chk_dn_short:
  assert property (dnHdr && (!(^dnData[11:10]) || dnData[30]
    && !(&dnData[28:15])) |-> dnLast) else $error("dn pay len");
endmodule : rpc_link_assertions

// >>> tb/tb_registration_packet_classifier.sv
/*
  Bench joining the manager end and the node end over one link.
  Assumes package, interface, both ends and checker compiled first.
*/
module tb_registration_packet_classifier;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [191:0] SKEY =
    192'h0123456789ABCDEFFEDCBA987654321013579BDF02468ACE;
  localparam logic [191:0] AKEY = ~SKEY;
  logic               clk     = 1'b0;
  logic               rst_n   = 1'b0;
  logic               upStart = 1'b0;
  logic               dnStart = 1'b0;
  rpc_pkg::rpc_kind_e txKind  = rpc_pkg::K_ASK;
  logic [13:0]        txId    = 14'h0000;
  logic               txRet   = 1'b0;
  logic [2:0]         txSar   = 3'h0;
  logic [1:0]         txProf  = 2'h0;
  logic [31:0]        txNonce = 32'hA5C30F12;
  logic               mRef, mDone, mInv, mRet, mDrop, mKeep, mLack, mLreq;
  logic               nRef, nDone, nInv, nRet, nLack, nLreq;
  logic               mBusy, nBusy;
  logic [1:0]         mProf;
  rpc_pkg::rpc_kind_e mKind, nKind;
  logic [13:0]        mId, nAid;
  logic [2:0]         nSar;
  logic [31:0]        mNonce, nNonce;
  logic [383:0]       nKeys;
  int                 nMismatch = 0;
  int                 numChecks = 0;
  int                 cycles = 0;
  int                 busyCycles = 0;

  rpc_link_if link ();

  rpc_manager_end i_rpc_manager_end (.clk(clk), .rst_n(rst_n),
    .link(link), .txStart(dnStart), .txKind(txKind), .txIdent(txId),
    .txRetain(txRet), .txSegLimit(txSar), .txProfile(txProf),
    .txNonce(txNonce), .txSubnetKeyWrapped(SKEY),
    .txAuthKeyWrapped(AKEY), .txBusy(mBusy), .txRefused(mRef),
    .rxDone(mDone), .rxInvalid(mInv), .rxKind(mKind), .rxIdent(mId),
    .rxRetain(mRet), .rxProfile(mProf), .rxNonce(mNonce), .dropConns(mDrop),
    .keepConns(mKeep), .leaveAck(mLack), .leaveReq(mLreq));

  rpc_node_end i_rpc_node_end (.clk(clk), .rst_n(rst_n), .link(link),
    .txStart(upStart), .txKind(txKind), .txIdent(txId),
    .txRetain(txRet), .txProfile(txProf), .txNonce(txNonce),
    .txBusy(nBusy), .txRefused(nRef), .rxDone(nDone), .rxInvalid(nInv),
    .rxKind(nKind), .assignedIdent(nAid), .rxRetain(nRet),
    .rxSegLimit(nSar), .rxNonce(nNonce), .rxKeys(nKeys),
    .leaveAck(nLack), .leaveReq(nLreq));

  rpc_link_assertions i_rpc_link_assertions (.clk(clk), .rst_n(rst_n),
    .dnValid(link.dnValid), .dnData(link.dnData), .dnLast(link.dnLast),
    .upValid(link.upValid), .upData(link.upData), .upLast(link.upLast));

  initial
    forever #2 clk = ~clk;

  task automatic summarize();
    $display("checks %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // Hang guard: whole run needs under a hundred cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      nMismatch++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [383:0] seen,
                       input logic [383:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // Sends one packet from node (up=1) or manager, returns on any answer
  task automatic xmit(input logic up, input rpc_pkg::rpc_kind_e k,
                      input logic [13:0] id, input logic r,
                      input logic [2:0] s, input logic [1:0] p);
    int n;
    n = 0;
    busyCycles = 0;
    @(posedge clk);
    txKind  <= k;
    txId    <= id;
    txRet   <= r;
    txSar   <= s;
    txProf  <= p;
    upStart <= up;
    dnStart <= !up;
    @(posedge clk);
    upStart <= 1'b0;
    dnStart <= 1'b0;
    do
    begin
      @(negedge clk);
      n++;
      if (up ? nBusy : mBusy)
        busyCycles++;
    end
    while (!(mDone || nDone || mInv || nInv || mRef || nRef) && n < 40);
    check("answer", {n < 40, mInv, nInv}, 3'h4);
  endtask : xmit

  task automatic tJoin();
    xmit(1'b1, rpc_pkg::K_ASK, 14'h0005, 1'b0, 3'h0, 2'h2);
    check("mKind", mKind, rpc_pkg::K_ASK);
    check("mId", mId, 14'h3FFF);
    check("mNonce", mNonce, txNonce);
    check("mProf", mProf, 2'h2);
    check("busyQ", busyCycles, 8'h02);
    check("drop", {mDone, mDrop, mKeep}, 3'h6);
    xmit(1'b1, rpc_pkg::K_ASK, 14'h3FFF, 1'b1, 3'h0, 2'h0);
    check("keep", {mDone, mRet, mDrop, mKeep}, 4'hD);
    $display("test join done");
  endtask : tJoin

  task automatic tGrant();
    xmit(1'b0, rpc_pkg::K_GRANT, 14'h0123, 1'b1, 3'h5, 2'h1);
    check("nKind", nKind, rpc_pkg::K_GRANT);
    check("nAid", {nAid, nRet}, {14'h0123, 1'b1});
    check("nSar", nSar, 3'h5);
    check("keys", nKeys, {SKEY, AKEY});
    check("nNonce", nNonce, txNonce);
    check("busyG", busyCycles, 8'h0E);
    xmit(1'b1, rpc_pkg::K_ACK, 14'h0123, 1'b1, 3'h5, 2'h2);
    check("ackKind", mKind, rpc_pkg::K_ACK);
    check("ackId", {mId, mRet}, {14'h0123, 1'b1});
    check("busyA", busyCycles, 8'h01);
    $display("test grant done");
  endtask : tGrant

  task automatic tReject();
    xmit(1'b0, rpc_pkg::K_GRANT, 14'h3FFF, 1'b0, 3'h0, 2'h0);
    check("refuse", {mRef, link.dnValid}, 2'h2);
    check("busyR", busyCycles, 8'h00);
    xmit(1'b1, rpc_pkg::K_ACK, 14'h3FFF, 1'b0, 3'h0, 2'h0);
    check("nRefuse", {nRef, link.upValid}, 2'h2);
    @(posedge clk);
    txNonce <= 32'h0BADF00D;
    xmit(1'b0, rpc_pkg::K_DENY, 14'h0123, 1'b1, 3'h5, 2'h2);
    check("deny", nKind, rpc_pkg::K_DENY);
    check("denyF", {nRet, nSar, nDone}, 5'h01);
    check("denyN", nNonce, 32'h0BADF00D);
    $display("test reject done");
  endtask : tReject

  task automatic tLeave();
    xmit(1'b1, rpc_pkg::K_LVN, 14'h0123, 1'b0, 3'h0, 2'h0);
    check("lvn", mKind, rpc_pkg::K_LVN);
    check("mReq", {mLreq, mLack}, 2'h2);
    xmit(1'b0, rpc_pkg::K_LVM, 14'h0123, 1'b0, 3'h0, 2'h0);
    check("nAck", {nLack, nLreq}, 2'h2);
    xmit(1'b0, rpc_pkg::K_LVM, 14'h0123, 1'b0, 3'h0, 2'h1);
    check("lvm", nKind, rpc_pkg::K_LVM);
    check("nReq", {nLreq, nLack}, 2'h2);
    xmit(1'b1, rpc_pkg::K_LVN, 14'h0123, 1'b0, 3'h0, 2'h0);
    check("mAck", {mLack, mLreq}, 2'h2);
    $display("test leave done");
  endtask : tLeave

  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    tJoin();
    tGrant();
    tReject();
    tLeave();
    summarize();
  end
endmodule : tb_registration_packet_classifier
